// file: inc/rtpm_regs.svh
// Register map, bit positions and timing figures of the reset monitor
`ifndef RTPM_REGS_SVH
`define RTPM_REGS_SVH
`define RTPM_ADDR_STATUS 8'h00
`define RTPM_ADDR_IRQ_STS 8'h04
`define RTPM_ADDR_IRQ_MASK 8'h08
`define RTPM_BIT_BOR 0
`define RTPM_BIT_POR 1
`define RTPM_BIT_PERN 2
`define RTPM_BIT_PARITY_CHECK_ENABLE 7
`define RTPM_IRQ_BOD 0
`define RTPM_IRQ_PAR 1
`define RTPM_IRQ_RDY 2
`define RTPM_IRQ_W 3
`define RTPM_BOR_RST 1'b0
`define RTPM_POR_RST 1'b0
`define RTPM_PERN_RST 1'b1
`define RTPM_CLK_MHZ 125
`define RTPM_POR_NS 2000
`define RTPM_POWER_UP_TIMER_MS 72
`define RTPM_OST_TOSC 1024
`define RTPM_POR_CYC (`RTPM_POR_NS * `RTPM_CLK_MHZ / 1000)
`define RTPM_POWER_UP_TIMER_CYC (`RTPM_POWER_UP_TIMER_MS * `RTPM_CLK_MHZ * 1000)
`define RTPM_CNT_W 24
`define RTPM_WORD_W 14
`endif

// file: inc/rtpm_pkg.sv
// Types shared by the reset monitor
package rtpm_pkg;
  typedef enum logic [1:0] {
    OSC_LP,
    OSC_XT,
    OSC_HS,
    OSC_RC
  } rtpm_osc_e;
  typedef enum logic [2:0] {
    ST_POR,
    ST_POWER_UP_TIMER,
    ST_OST,
    ST_READY,
    ST_PERR
  } rtpm_state_e;
  typedef struct packed {
    rtpm_osc_e oscMode;
    logic powerTimerEnableN;
    logic brownoutDetectEnable;
    logic parityCheckEnable;
  } rtpm_cfg_s;
  typedef struct packed {
    logic valid;
    logic parityEven;
    logic parityOdd;
    logic [13:0] word;
  } rtpm_fetch_s;
endpackage

// file: core/rtpm_top.sv
// Reset sequencer, reset cause status and program word parity monitor
`timescale 1ns/10ps
`default_nettype none
`include "rtpm_regs.svh"
module rtpm_top #(
  parameter int POWER_UP_TIMER_CYC = `RTPM_POWER_UP_TIMER_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic externalResetN,
  input wire logic brownoutDetect,
  input wire logic sleepWakeReq,
  input wire rtpm_pkg::rtpm_cfg_s cfg,
  input wire rtpm_pkg::rtpm_fetch_s fetch,
  output logic coreHold,
  output logic irq
);
  localparam logic [`RTPM_CNT_W-1:0] POR_END =
    `RTPM_CNT_W'(`RTPM_POR_CYC - 1);
  localparam logic [`RTPM_CNT_W-1:0] POWER_UP_TIMER_END =
    `RTPM_CNT_W'(POWER_UP_TIMER_CYC - 1);
  localparam logic [`RTPM_CNT_W-1:0] OST_END =
    `RTPM_CNT_W'(`RTPM_OST_TOSC - 1);

  rtpm_pkg::rtpm_state_e stateReg;
  logic [`RTPM_CNT_W-1:0] cntReg;
  logic [2:0] mclrQ;
  logic [2:0] bodQ;
  logic mclrStable;
  logic bodStable;
  logic bodEvent;
  logic isRc;
  logic pwrtOn;
  logic [6:0] evenBits;
  logic [6:0] oddBits;
  logic parityBad;
  logic parityHit;
  logic readyPrevReg;
  logic readyEvent;
  logic borReg;
  logic porReg;
  logic perNReg;
  logic [`RTPM_IRQ_W-1:0] irqStsReg;
  logic [`RTPM_IRQ_W-1:0] irqMaskReg;
  logic [`RTPM_IRQ_W-1:0] irqEvents;
  logic [31:0] prdataReg;
  logic preadyReg;
  logic pslverrReg;
  logic coreHoldReg;
  logic irqReg;
  logic acc;
  logic wrDone;
  logic mapped;
  logic stsWr;
  logic [31:0] rdMux;

  assign isRc = cfg.oscMode == rtpm_pkg::OSC_RC;
  assign pwrtOn = !cfg.powerTimerEnableN;

  // Pin synchronisers, change taken when stages two and three agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mclrQ <= 3'h0;
      bodQ <= 3'h0;
    end else begin
      mclrQ <= {mclrQ[1:0], externalResetN};
      bodQ <= {bodQ[1:0], brownoutDetect};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mclrStable <= 1'b0;
      bodStable <= 1'b0;
    end else begin
      if (mclrQ[1] == mclrQ[2]) begin
        mclrStable <= mclrQ[2];
      end
      if (bodQ[1] == bodQ[2]) begin
        bodStable <= bodQ[2];
      end
    end
  end

  assign bodEvent = bodStable && cfg.brownoutDetectEnable;

  // Parity split of the fetched word
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_split
      assign evenBits[gi] = fetch.word[2*gi];
      assign oddBits[gi] = fetch.word[2*gi+1];
    end
  endgenerate

  assign parityBad = (fetch.parityEven ^ (^evenBits)) |
    (~fetch.parityOdd ^ (^oddBits));
  // Only a flag is kept, never the fetch address
  assign parityHit = fetch.valid && cfg.parityCheckEnable &&
    stateReg == rtpm_pkg::ST_READY && parityBad;

  // Time-out sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stateReg <= rtpm_pkg::ST_POR;
      cntReg <= '0;
    end else if (bodEvent) begin
      stateReg <= rtpm_pkg::ST_POWER_UP_TIMER;
      cntReg <= '0;
    end else if (parityHit) begin
      stateReg <= rtpm_pkg::ST_PERR;
      cntReg <= '0;
    end else begin
      cntReg <= cntReg + 1'b1;
      case (stateReg)
        rtpm_pkg::ST_POR: begin
          if (cntReg == POR_END) begin
            cntReg <= '0;
            if (pwrtOn) begin
              stateReg <= rtpm_pkg::ST_POWER_UP_TIMER;
            end else if (isRc) begin
              stateReg <= rtpm_pkg::ST_READY;
            end else begin
              stateReg <= rtpm_pkg::ST_OST;
            end
          end
        end
        rtpm_pkg::ST_POWER_UP_TIMER: begin
          if (cntReg == POWER_UP_TIMER_END) begin
            cntReg <= '0;
            if (isRc) begin
              stateReg <= rtpm_pkg::ST_READY;
            end else begin
              stateReg <= rtpm_pkg::ST_OST;
            end
          end
        end
        rtpm_pkg::ST_OST: begin
          if (cntReg == OST_END) begin
            cntReg <= '0;
            stateReg <= rtpm_pkg::ST_READY;
          end
        end
        rtpm_pkg::ST_READY: begin
          cntReg <= '0;
          if (sleepWakeReq && !isRc) begin
            stateReg <= rtpm_pkg::ST_OST;
          end
        end
        rtpm_pkg::ST_PERR: begin
          cntReg <= '0;
          stateReg <= rtpm_pkg::ST_READY;
        end
        default: begin
          cntReg <= '0;
          stateReg <= rtpm_pkg::ST_POR;
        end
      endcase
    end
  end

  // Core held in reset while timing or while the pin is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      coreHoldReg <= 1'b1;
    end else begin
      coreHoldReg <= stateReg != rtpm_pkg::ST_READY ||
        !mclrStable || parityHit;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      readyPrevReg <= 1'b0;
    end else begin
      readyPrevReg <= stateReg == rtpm_pkg::ST_READY;
    end
  end

  assign readyEvent = stateReg == rtpm_pkg::ST_READY && !readyPrevReg;

  // APB access decode
  assign acc = psel && penable;
  assign wrDone = acc && preadyReg && pwrite;
  assign mapped = paddr == `RTPM_ADDR_STATUS ||
    paddr == `RTPM_ADDR_IRQ_STS || paddr == `RTPM_ADDR_IRQ_MASK;
  assign stsWr = wrDone && pstrb[0] && paddr == `RTPM_ADDR_STATUS;

  // Reset cause flags, hardware events win over software writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      borReg <= `RTPM_BOR_RST;
    end else if (bodEvent) begin
      borReg <= 1'b0;
    end else if (stsWr) begin
      borReg <= pwdata[`RTPM_BIT_BOR];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      porReg <= `RTPM_POR_RST;
    end else if (stsWr) begin
      porReg <= pwdata[`RTPM_BIT_POR];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      perNReg <= `RTPM_PERN_RST;
    end else if (parityHit) begin
      perNReg <= 1'b0;
    end else if (stsWr) begin
      perNReg <= pwdata[`RTPM_BIT_PERN];
    end
  end

  // Interrupt status, set wins over write-one-to-clear
  always_comb begin
    irqEvents = '0;
    irqEvents[`RTPM_IRQ_BOD] = bodEvent;
    irqEvents[`RTPM_IRQ_PAR] = parityHit;
    irqEvents[`RTPM_IRQ_RDY] = readyEvent;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqStsReg <= '0;
    end else if (wrDone && pstrb[0] && paddr == `RTPM_ADDR_IRQ_STS) begin
      irqStsReg <= (irqStsReg & ~pwdata[`RTPM_IRQ_W-1:0]) | irqEvents;
    end else begin
      irqStsReg <= irqStsReg | irqEvents;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqMaskReg <= '0;
    end else if (wrDone && pstrb[0] &&
        paddr == `RTPM_ADDR_IRQ_MASK) begin
      irqMaskReg <= pwdata[`RTPM_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqReg <= 1'b0;
    end else begin
      irqReg <= |(irqStsReg & irqMaskReg);
    end
  end

  // Read data selection
  always_comb begin
    rdMux = 32'h0;
    case (paddr)
      `RTPM_ADDR_STATUS: begin
        rdMux[`RTPM_BIT_BOR] = borReg;
        rdMux[`RTPM_BIT_POR] = porReg;
        rdMux[`RTPM_BIT_PERN] = perNReg;
        rdMux[`RTPM_BIT_PARITY_CHECK_ENABLE] = cfg.parityCheckEnable;
      end
      `RTPM_ADDR_IRQ_STS: begin
        rdMux[`RTPM_IRQ_W-1:0] = irqStsReg;
      end
      `RTPM_ADDR_IRQ_MASK: begin
        rdMux[`RTPM_IRQ_W-1:0] = irqMaskReg;
      end
      default: begin
        rdMux = 32'h0;
      end
    endcase
  end

  // Answer one cycle into the access phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      preadyReg <= 1'b0;
      pslverrReg <= 1'b0;
      prdataReg <= 32'h0;
    end else begin
      preadyReg <= acc && !preadyReg;
      pslverrReg <= acc && !preadyReg && !mapped;
      if (acc && !preadyReg && !pwrite) begin
        prdataReg <= rdMux;
      end
    end
  end

  assign prdata = prdataReg;
  assign pready = preadyReg;
  assign pslverr = pslverrReg;
  assign coreHold = coreHoldReg;
  assign irq = irqReg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_power_up_timer_after_por: assert property (
    stateReg == rtpm_pkg::ST_POWER_UP_TIMER &&
    $past(stateReg) == rtpm_pkg::ST_POR |->
    $past(cntReg) == POR_END)
    else $error("power timer began before power-on delay ended");

  a_ost_after_power_up_timer: assert property (
    stateReg == rtpm_pkg::ST_OST &&
    $past(stateReg) == rtpm_pkg::ST_POWER_UP_TIMER |->
    $past(cntReg) == POWER_UP_TIMER_END)
    else $error("startup timer began before power timer ended");

  a_rc_no_wait: assert property (
    stateReg == rtpm_pkg::ST_POR && cntReg == POR_END && isRc &&
    !pwrtOn && !bodEvent |=> stateReg == rtpm_pkg::ST_READY)
    else $error("RC mode without power timer still waited");

  a_pin_no_restart: assert property (
    stateReg == rtpm_pkg::ST_POWER_UP_TIMER && $rose(mclrStable) &&
    cntReg != POWER_UP_TIMER_END && !bodEvent |=>
    cntReg == $past(cntReg) + 1'b1)
    else $error("power timer restarted on pin release");

  a_exec_at_once: assert property (
    stateReg == rtpm_pkg::ST_READY && $rose(mclrStable) &&
    !parityHit |=> !coreHold)
    else $error("execution delayed after pin release");

  a_bor_cleared: assert property (
    bodEvent |=> !borReg[*2])
    else $error("brown-out flag not cleared");

  a_por_kept: assert property (
    porReg && !stsWr |=> porReg)
    else $error("power-on flag cleared outside power-on");

  a_per_cleared: assert property (
    parityHit |=> !perNReg && coreHold)
    else $error("parity error did not reset or clear flag");

  a_per_sw_only: assert property (
    $rose(perNReg) |-> $past(stsWr) && $past(pwdata[`RTPM_BIT_PERN]))
    else $error("parity flag set by hardware");

  a_parity_check_enable_read: assert property (
    $rose(preadyReg) && !$past(pwrite) &&
    $past(paddr) == `RTPM_ADDR_STATUS |->
    prdata[`RTPM_BIT_PARITY_CHECK_ENABLE] == $past(cfg.parityCheckEnable))
    else $error("parity enable readback wrong");

  a_ost_length: assert property (
    stateReg == rtpm_pkg::ST_OST && cntReg == OST_END &&
    !bodEvent && !parityHit |=> stateReg == rtpm_pkg::ST_READY)
    else $error("startup timer length wrong");

endmodule
`default_nettype wire

// file: test/rtpm_partner.sv
// Model of the reset pin and the program memory fetch source
`timescale 1ns/10ps
`default_nettype none
module rtpm_partner (
  input wire logic clk,
  input wire logic pinLow,
  input wire logic go,
  input wire logic [1:0] bad,
  output logic externalResetN,
  output var rtpm_pkg::rtpm_fetch_s fetch
);
  logic [13:0] w = 14'h1a5c;
  assign externalResetN = ~pinLow;
  initial fetch = '0;
  always @(posedge clk) begin
    fetch.valid <= go;
    if (go) begin
      w <= w + 14'h0b37;
      fetch.word <= w;
      fetch.parityEven <= ^(w & 14'h1555) ^ bad[0];
      fetch.parityOdd <= ~^(w & 14'h2aaa) ^ bad[1];
    end else begin
      fetch.word <= ~fetch.word;
    end
  end
endmodule
`default_nettype wire

// file: test/rtpm_top_tb.sv
// Self-checking bench of the reset monitor
`timescale 1ns/10ps
`default_nettype none
`include "rtpm_regs.svh"
module rtpm_top_tb;
  logic clk = 0;
  logic sys_rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, se, externalResetN, coreHold, irq, h;
  logic brownoutDetect = 0;
  logic sleepWakeReq = 0;
  logic pinLow = 0;
  logic go = 0;
  logic [1:0] bad = 2'h0;
  rtpm_pkg::rtpm_cfg_s cfg = '{rtpm_pkg::OSC_XT, 1'b0, 1'b1, 1'b1};
  rtpm_pkg::rtpm_fetch_s fetch;
  int errTotal = 0;
  int totalChecks = 0;
  int n, e;
  always #4 clk = ~clk;
  rtpm_top #(.POWER_UP_TIMER_CYC(20)) u_dut (.clk, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
    .externalResetN, .brownoutDetect, .sleepWakeReq, .cfg, .fetch,
    .coreHold, .irq);
  rtpm_partner u_far (.clk, .pinLow, .go, .bad, .externalResetN, .fetch);
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x,
      input string m);
    totalChecks++;
    if (g !== x) begin
      errTotal++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task rst;
    sys_rst <= 1;
    repeat (6) @(posedge clk);
    sys_rst <= 0;
  endtask
  task automatic cnt(input logic v, output int c);
    c = 0;
    while (coreHold !== v && c < 3000) begin
      @(posedge clk);
      c++;
    end
    if (coreHold !== v) begin
      errTotal++;
      $display("mismatch at %0t: hold level never reached", $time);
    end
  endtask
  task automatic send(input logic [1:0] b, output logic hit);
    bad <= b;
    go <= 1;
    @(posedge clk);
    go <= 0;
    hit = 0;
    repeat (4) begin
      @(posedge clk);
      hit = hit | coreHold;
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    errTotal++;
    wrap_up;
  end
  initial begin
    rst;
    apb(0, `RTPM_ADDR_STATUS, 0);
    chk(rd, 32'h84, "status after power-on");
    for (int i = 0; i < 8; i++) begin
      cfg.oscMode <= rtpm_pkg::rtpm_osc_e'(i[2:1]);
      cfg.powerTimerEnableN <= i[0];
      rst;
      cnt(0, n);
      e = 250 + (i[0] ? 0 : 20) + (i[2:1] == 3 ? 0 : `RTPM_OST_TOSC);
      chk(32'(n >= e - 2 && n <= e + 8), 1, "time-out length");
    end
    $display("test timing done");
    cfg <= '{rtpm_pkg::OSC_XT, 1'b0, 1'b1, 1'b1};
    pinLow <= 1;
    rst;
    repeat (1400) @(posedge clk);
    chk(coreHold, 1, "held by pin");
    pinLow <= 0;
    cnt(0, n);
    chk(32'(n <= 6), 1, "pin release");
    apb(1, `RTPM_ADDR_STATUS, 32'h07);
    apb(0, `RTPM_ADDR_STATUS, 0);
    chk(rd, 32'h87, "status write");
    apb(1, `RTPM_ADDR_IRQ_MASK, 32'h2);
    chk(irq, 0, "masked ready event");
    send(0, h);
    chk(h, 0, "good word");
    for (int b = 1; b < 3; b++) begin
      send(b[1:0], h);
      chk(h, 1, "parity reset");
      cnt(0, n);
      apb(0, `RTPM_ADDR_STATUS, 0);
      chk(rd, 32'h83, "parity flag");
      chk(irq, 1, "irq raised");
      apb(0, `RTPM_ADDR_IRQ_STS, 0);
      chk(rd, 32'h6, "irq status");
      apb(1, `RTPM_ADDR_IRQ_STS, 32'h7);
      apb(0, `RTPM_ADDR_IRQ_STS, 0);
      chk(rd, 0, "irq cleared");
      chk(irq, 0, "irq dropped");
      apb(1, `RTPM_ADDR_STATUS, 32'h07);
    end
    $display("test parity done");
    cfg.parityCheckEnable <= 0;
    rst;
    cnt(0, n);
    apb(0, `RTPM_ADDR_STATUS, 0);
    chk(rd, 32'h04, "enable readback");
    send(1, h);
    chk(h, 0, "check disabled");
    apb(1, `RTPM_ADDR_STATUS, 32'h07);
    brownoutDetect <= 1;
    repeat (10) @(posedge clk);
    brownoutDetect <= 0;
    chk(coreHold, 1, "brown-out hold");
    cnt(0, n);
    chk(32'(n >= 1040 && n <= 1060), 1, "brown-out delay");
    apb(0, `RTPM_ADDR_STATUS, 0);
    chk(rd, 32'h06, "brown-out flag");
    sleepWakeReq <= 1;
    @(posedge clk);
    sleepWakeReq <= 0;
    cnt(1, n);
    cnt(0, n);
    chk(32'(n >= 1018 && n <= 1030), 1, "wake delay");
    apb(0, 8'h0c, 0);
    chk(se, 1, "unmapped error");
    chk(rd, 0, "unmapped data");
    $display("test brown-out and wake done");
    wrap_up;
  end
endmodule
`default_nettype wire
